//--- ihw_core.sv
`timescale 1ns/1ps
`include "ihw_defines.svh"
module ihw_core (
  // Link to the interrupt unit
  ihw_if.core unit,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ihw_pkg::*;

  logic clk;
  logic rst_n;
  logic setup;
  logic wr;
  logic mapped;
  logic is_vec;
  logic [3:0] vidx;
  ihw_byte_t vec_mem [`IHW_VEC_BYTES];
  logic op_pend_r;
  logic halt_pend_r;
  ihw_byte_t op_out_r;
  logic racc_pend_r;
  logic racc_wait_r;
  logic we_r;
  ihw_byte_t addr_r;
  ihw_byte_t wdata_r;
  ihw_byte_t rd_r;
  logic vf_ack_r;
  ihw_byte_t vf_data_r;
  ihw_addr_t pc_r;
  ihw_addr_t saved_pc_r;
  logic branch_seen_r;
  logic [31:0] prdata_r;

  assign clk = unit.pclk;
  assign rst_n = unit.presetn;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign vidx = 4'(paddr[5:2]);
  assign is_vec = (paddr[11:6] == 6'(`IHW_APB_VEC_BASE >> 6)) && (paddr[1:0] == 2'b00)
                  && (vidx < 4'(`IHW_VEC_BYTES));
  assign mapped = is_vec || paddr == `IHW_APB_OP || paddr == `IHW_APB_RACC
                  || paddr == `IHW_APB_STAT || paddr == `IHW_APB_PC;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        `IHW_APB_RACC: prdata_r <= {23'h0, racc_pend_r | racc_wait_r, rd_r};
        `IHW_APB_STAT: prdata_r <= {27'h0, branch_seen_r, op_pend_r,
                                    racc_pend_r | racc_wait_r, unit.sys_reset,
                                    !unit.core_clk_en};
        `IHW_APB_PC: prdata_r <= {16'h0, pc_r};
        default: prdata_r <= is_vec ? {24'h0, vec_mem[vidx]} : 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_r;

  // Vector table bytes
  always_ff @(posedge clk) begin
    if (wr && is_vec) begin
      vec_mem[vidx] <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Opcode issue
  // ****************************************************************

  // Halt is preceded by a no-operation sent automatically
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_pend_r <= 1'b0;
      halt_pend_r <= 1'b0;
      op_out_r <= `IHW_OP_NOP;
    end else if (unit.sys_reset) begin
      op_pend_r <= 1'b0;
      halt_pend_r <= 1'b0;
    end else if (unit.op_valid) begin
      op_pend_r <= halt_pend_r;
      halt_pend_r <= 1'b0;
      op_out_r <= `IHW_OP_HALT;
    end else if (wr && paddr == `IHW_APB_OP && !op_pend_r) begin
      op_pend_r <= 1'b1;
      halt_pend_r <= (pwdata[7:0] == `IHW_OP_HALT);
      op_out_r <= (pwdata[7:0] == `IHW_OP_HALT) ? `IHW_OP_NOP : pwdata[7:0];
    end
  end
  assign unit.op_valid = op_pend_r && unit.core_clk_en;
  assign unit.op_code = op_out_r;

  // ****************************************************************
  // Register access
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      racc_pend_r <= 1'b0;
      racc_wait_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rd_r <= 8'h00;
    end else if (unit.reg_req) begin
      racc_pend_r <= 1'b0;
      racc_wait_r <= 1'b1;
    end else if (unit.reg_ack) begin
      racc_wait_r <= 1'b0;
      rd_r <= unit.reg_rdata;
    end else if (wr && paddr == `IHW_APB_RACC && !racc_pend_r && !racc_wait_r) begin
      racc_pend_r <= 1'b1;
      we_r <= pwdata[`IHW_RACC_WE_BIT];
      addr_r <= pwdata[15:8];
      wdata_r <= pwdata[7:0];
    end
  end
  assign unit.reg_req = racc_pend_r && unit.core_clk_en;
  assign unit.reg_we = we_r;
  assign unit.reg_addr = addr_r;
  assign unit.reg_wdata = wdata_r;

  // ****************************************************************
  // Vector fetch and program counter
  // ****************************************************************

  // Each fetch request answered one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vf_ack_r <= 1'b0;
      vf_data_r <= 8'h00;
    end else begin
      vf_ack_r <= unit.vf_req && !vf_ack_r;
      vf_data_r <= (unit.vf_addr < 4'(`IHW_VEC_BYTES)) ? vec_mem[unit.vf_addr] : 8'h00;
    end
  end
  assign unit.vf_ack = vf_ack_r;
  assign unit.vf_data = vf_data_r;

  // Counter steps per opcode, so a return lands after the halt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= 16'h0000;
      saved_pc_r <= 16'h0000;
    end else if (unit.sys_reset) begin
      pc_r <= 16'h0000;
    end else if (unit.int_branch) begin
      saved_pc_r <= pc_r;
      pc_r <= unit.isr_addr;
    end else if (unit.op_valid && unit.op_code == `IHW_OP_RETURN) begin
      pc_r <= saved_pc_r;
    end else if (unit.op_valid) begin
      pc_r <= pc_r + 16'h0001;
    end else if (wr && paddr == `IHW_APB_PC) begin
      pc_r <= pwdata[15:0];
    end
  end

  // Sticky branch flag, write one to clear, a new branch wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      branch_seen_r <= 1'b0;
    end else if (unit.int_branch) begin
      branch_seen_r <= 1'b1;
    end else if (wr && paddr == `IHW_APB_STAT && pwdata[`IHW_STAT_BRANCH_BIT]) begin
      branch_seen_r <= 1'b0;
    end
  end
endmodule

//--- ihw_defines.svh
`ifndef IHW_DEFINES_SVH
`define IHW_DEFINES_SVH

// ****************************************************************
// Unit register offsets (core side)
// ****************************************************************
`define IHW_ADDR_PORT_OUT 8'h02
`define IHW_ADDR_PRIO_SEL 8'hf9
`define IHW_ADDR_PEND_FLAGS 8'hfa
`define IHW_ADDR_EN_MASK 8'hfb
`define IHW_ADDR_STATUS_FLAGS 8'hfc

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define IHW_RST_BYTE 8'h00
`define IHW_RST_PEND 4'h0
`define IHW_GLOBAL_EN_BIT 7
`define IHW_NUM_SRC 4

// ****************************************************************
// Opcodes seen by the unit
// ****************************************************************
`define IHW_OP_NOP 8'hff
`define IHW_OP_HALT 8'h7f
`define IHW_OP_REFRESH 8'h5f
`define IHW_OP_RETURN 8'hbf

// ****************************************************************
// Vector byte locations (high byte, low byte follows)
// ****************************************************************
`define IHW_VEC_PIN_THREE 4'h2
`define IHW_VEC_PIN_ONE 4'h4
`define IHW_VEC_TMR_ZERO 4'h8
`define IHW_VEC_TMR_ONE 4'ha
`define IHW_VEC_BYTES 12

// ****************************************************************
// Timing
// ****************************************************************
`define IHW_CLK_MHZ 125
`define IHW_WDT_TIMEOUT_MS 10
`define IHW_WDT_TICK_US 1
`define IHW_WDT_DIV (`IHW_WDT_TICK_US * `IHW_CLK_MHZ)
`define IHW_WDT_TICKS (`IHW_WDT_TIMEOUT_MS * 1000 / `IHW_WDT_TICK_US)
`define IHW_RST_HOLD 5'd18

// ****************************************************************
// Sequencer APB map
// ****************************************************************
`define IHW_APB_OP 12'h000
`define IHW_APB_RACC 12'h004
`define IHW_APB_STAT 12'h008
`define IHW_APB_PC 12'h00c
`define IHW_APB_VEC_BASE 12'h040
`define IHW_RACC_WE_BIT 16
`define IHW_STAT_BRANCH_BIT 4

`endif

//--- ihw_edge_sync.sv
`timescale 1ns/1ps
module ihw_edge_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and detected falling edge
  input wire logic pin,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Two-stage synchroniser, then history for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // High-to-low seen on synchronised pin
  assign fall = s3_r & ~s2_r;
endmodule

//--- ihw_if.sv
`timescale 1ns/1ps
interface ihw_if (
  input logic pclk,
  input logic presetn
);
  logic op_valid;
  logic [7:0] op_code;
  logic reg_req;
  logic reg_we;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_ack;
  logic [7:0] reg_rdata;
  logic vf_req;
  logic [3:0] vf_addr;
  logic vf_ack;
  logic [7:0] vf_data;
  logic int_branch;
  logic [15:0] isr_addr;
  logic core_clk_en;
  logic sys_reset;

  modport unit (
    input pclk, presetn, op_valid, op_code, reg_req, reg_we, reg_addr, reg_wdata,
    input vf_ack, vf_data,
    output reg_ack, reg_rdata, vf_req, vf_addr, int_branch, isr_addr, core_clk_en,
    output sys_reset
  );
  modport core (
    input pclk, presetn, reg_ack, reg_rdata, vf_req, vf_addr, int_branch, isr_addr,
    input core_clk_en, sys_reset,
    output op_valid, op_code, reg_req, reg_we, reg_addr, reg_wdata, vf_ack, vf_data
  );
endinterface

//--- ihw_link_sva.sv
`timescale 1ns/1ps
// ****************************************
// Link checker
// ****************************************
module ihw_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core to unit
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic reg_req,
  input wire logic vf_ack,
  // Unit to core
  input wire logic reg_ack,
  input wire logic vf_req,
  input wire logic [3:0] vf_addr,
  input wire logic int_branch,
  input wire logic core_clk_en,
  input wire logic sys_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reg_ack_cause: assert property (reg_ack |-> $past(reg_req && core_clk_en))
    else $error("register ack without request");
  a_vec_loc_legal: assert property ($rose(vf_req) |-> vf_addr inside {4'h2, 4'h4, 4'h8, 4'ha})
    else $error("bad vector location");
  a_vec_low_next: assert property (vf_req && vf_ack && !vf_addr[0] |=>
    vf_req && vf_addr == $past(vf_addr) + 4'h1)
    else $error("low vector byte not next");
  a_branch_after_fetch: assert property (int_branch |-> $past(vf_ack) && $past(vf_addr[0]))
    else $error("branch before low byte");
  a_branch_resume: assert property (int_branch |=> !int_branch && core_clk_en)
    else $error("core not resumed after branch");
  a_fetch_stops_core: assert property (vf_req |-> !core_clk_en)
    else $error("core runs during fetch");
  a_halt_stop: assert property (op_valid && op_code == 8'h7f && $past(op_valid) &&
    $past(op_code) == 8'hff |=> !core_clk_en)
    else $error("halt did not stop core");
  a_stop_no_ops: assert property (!core_clk_en |-> !op_valid && !reg_req)
    else $error("op issued while stopped");
  a_reset_hold: assert property ($rose(sys_reset) |-> sys_reset [*8])
    else $error("internal reset too short");
  a_reset_core_off: assert property (sys_reset |-> !core_clk_en)
    else $error("core runs in reset");
endmodule

//--- ihw_pkg.sv
package ihw_pkg;
  typedef logic [7:0] ihw_byte_t;
  typedef logic [15:0] ihw_addr_t;
  typedef enum logic [2:0] {ST_RUN, ST_HALT, ST_FETCH_HI, ST_FETCH_LO, ST_BRANCH} ihw_state_t;
endpackage

//--- ihw_unit.sv
// How it works
// - Four maskable prioritised interrupt requests
// - Pins latch on falling edge, timers on end
// - Service needs global and per-source enable
// - Priority select register picks single winner
// - Grant disables interrupts, saves state, vectors
// - Vector is two bytes, high byte first
// - Vectors at 2, 4, 8 and 10
// - Masked requests still recorded for polling
// - Halt stops core; timers, edges keep running
// - Interrupt wakes halt, resumes after halt
// - Software enables a source before halt
// - No-operation must directly precede halt
// - Output latch held during halt
// - Watchdog always running on own tick
// - Refresh opcode clears watchdog counter
// - Refresh leaves status flags untouched
// - Software refreshes within watchdog timeout
// - Low supply forces reset until restored
// - Watchdog timeout is 10 ms
// - Timer request needs prescaler and counter end
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ihw_defines.svh"
module ihw_unit #(
  parameter int WDT_TICKS = `IHW_WDT_TICKS,
  parameter int WDT_DIV = `IHW_WDT_DIV
) (
  // Core sequencer side
  ihw_if.unit core,
  // Edge-triggered request pins
  input wire logic edge_input_one,
  input wire logic edge_input_three,
  // Counter/timer end-of-count strobes, [0] zero, [1] one
  input wire logic [1:0] tmr_pre_end,
  input wire logic [1:0] tmr_cnt_end,
  // Supply monitor, high while supply is below trip
  input wire logic low_supply_trip_level,
  // Output port latch
  output ihw_pkg::ihw_byte_t port_out
);
  import ihw_pkg::*;

  logic clk;
  logic rst_n;
  logic [1:0] pins;
  logic [1:0] fall;
  logic [3:0] set_vec;
  ihw_state_t state_r;
  ihw_byte_t prio_r;
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  ihw_byte_t mask_r;
  ihw_byte_t flags_r;
  ihw_byte_t saved_flags_r;
  ihw_byte_t port_r;
  ihw_byte_t rdata_r;
  logic ack_r;
  logic last_nop_r;
  logic [3:0] vloc_r;
  ihw_addr_t isr_r;
  logic [3:0] elig;
  logic any_elig;
  logic [1:0] win;
  logic [1:0] win_rank;
  logic [3:0] win_loc;
  logic grant;
  logic run_op;
  logic reg_wr;
  logic refresh;
  logic ret_op;
  logic [31:0] wdt_div_r;
  logic [31:0] wdt_cnt_r;
  logic wdt_tick;
  logic bite;
  logic lv_s1_r;
  logic lv_s2_r;
  logic [4:0] rst_cnt_r;
  logic srst;

  assign clk = core.pclk;
  assign rst_n = core.presetn;

  // ****************************************************************
  // Request sources
  // ****************************************************************
  assign pins = {edge_input_one, edge_input_three};

  // One synchroniser and falling-edge detector per pin
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_edge
      ihw_edge_sync u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .pin(pins[g]),
        .fall(fall[g])
      );
    end
  endgenerate

  // Bit 0 pin three, bit 1 pin one, bits 2..3 timers
  assign set_vec = {tmr_pre_end & tmr_cnt_end, fall};

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  assign run_op = core.op_valid && (state_r == ST_RUN);
  assign refresh = run_op && (core.op_code == `IHW_OP_REFRESH);
  assign ret_op = run_op && (core.op_code == `IHW_OP_RETURN);
  assign reg_wr = core.reg_req && core.reg_we && (state_r == ST_RUN);

  // Remembers whether the last executed opcode was a no-operation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_nop_r <= 1'b0;
    end else if (srst) begin
      last_nop_r <= 1'b0;
    end else if (run_op) begin
      last_nop_r <= (core.op_code == `IHW_OP_NOP);
    end
  end

  // ****************************************************************
  // Priority resolution
  // ****************************************************************
  assign elig = pend_r & mask_r[3:0] & {4{mask_r[`IHW_GLOBAL_EN_BIT]}};
  assign any_elig = |elig;

  // Lowest two-bit rank wins; ties go to the lower source index
  always_comb begin
    win = 2'd0;
    win_rank = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (elig[i] && (prio_r[2*i +: 2] <= win_rank)) begin
        win = 2'(i);
        win_rank = prio_r[2*i +: 2];
      end
    end
  end

  // Fixed vector location per source
  always_comb begin
    case (win)
      2'd0: win_loc = `IHW_VEC_PIN_THREE;
      2'd1: win_loc = `IHW_VEC_PIN_ONE;
      2'd2: win_loc = `IHW_VEC_TMR_ZERO;
      default: win_loc = `IHW_VEC_TMR_ONE;
    endcase
  end

  assign grant = any_elig && ((state_r == ST_RUN) || (state_r == ST_HALT));

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else if (srst) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (grant) begin
            state_r <= ST_FETCH_HI;
          end else if (run_op && core.op_code == `IHW_OP_HALT && last_nop_r) begin
            state_r <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (grant) begin
            state_r <= ST_FETCH_HI;
          end
        end
        ST_FETCH_HI: begin
          if (core.vf_ack) begin
            state_r <= ST_FETCH_LO;
          end
        end
        ST_FETCH_LO: begin
          if (core.vf_ack) begin
            state_r <= ST_BRANCH;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Vector byte address and assembled service address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vloc_r <= 4'h0;
      isr_r <= 16'h0000;
    end else if (grant) begin
      vloc_r <= win_loc;
    end else if (state_r == ST_FETCH_HI && core.vf_ack) begin
      isr_r[15:8] <= core.vf_data;
      vloc_r <= vloc_r + 4'h1;
    end else if (state_r == ST_FETCH_LO && core.vf_ack) begin
      isr_r[7:0] <= core.vf_data;
    end
  end

  assign core.vf_req = (state_r == ST_FETCH_HI) || (state_r == ST_FETCH_LO);
  assign core.vf_addr = vloc_r;
  assign core.int_branch = (state_r == ST_BRANCH);
  assign core.isr_addr = isr_r;
  assign core.core_clk_en = (state_r == ST_RUN) && !srst;

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Pending flags: grant clears, software writes, new events win
  always_comb begin
    pend_nxt = pend_r;
    if (reg_wr && core.reg_addr == `IHW_ADDR_PEND_FLAGS) begin
      pend_nxt = core.reg_wdata[3:0];
    end
    if (grant) begin
      pend_nxt[win] = 1'b0;
    end
    pend_nxt = pend_nxt | set_vec;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= `IHW_RST_PEND;
    end else if (srst) begin
      pend_r <= `IHW_RST_PEND;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Enable mask: grant drops global enable, return restores it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `IHW_RST_BYTE;
    end else if (srst) begin
      mask_r <= `IHW_RST_BYTE;
    end else if (grant) begin
      mask_r[`IHW_GLOBAL_EN_BIT] <= 1'b0;
    end else if (ret_op) begin
      mask_r[`IHW_GLOBAL_EN_BIT] <= 1'b1;
    end else if (reg_wr && core.reg_addr == `IHW_ADDR_EN_MASK) begin
      mask_r <= core.reg_wdata;
    end
  end

  // Priority select, write only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_r <= `IHW_RST_BYTE;
    end else if (reg_wr && core.reg_addr == `IHW_ADDR_PRIO_SEL) begin
      prio_r <= core.reg_wdata;
    end
  end

  // Status flags saved on grant, restored on return; refresh leaves them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= `IHW_RST_BYTE;
      saved_flags_r <= `IHW_RST_BYTE;
    end else if (grant) begin
      saved_flags_r <= flags_r;
    end else if (ret_op) begin
      flags_r <= saved_flags_r;
    end else if (reg_wr && core.reg_addr == `IHW_ADDR_STATUS_FLAGS) begin
      flags_r <= core.reg_wdata;
    end
  end

  // Output latch, only writable while the core runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_r <= `IHW_RST_BYTE;
    end else if (reg_wr && core.reg_addr == `IHW_ADDR_PORT_OUT) begin
      port_r <= core.reg_wdata;
    end
  end
  assign port_out = port_r;

  // Register access answer, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdata_r <= `IHW_RST_BYTE;
    end else begin
      ack_r <= core.reg_req && (state_r == ST_RUN);
      case (core.reg_addr)
        `IHW_ADDR_PEND_FLAGS: rdata_r <= {4'h0, pend_r};
        `IHW_ADDR_EN_MASK: rdata_r <= mask_r;
        `IHW_ADDR_STATUS_FLAGS: rdata_r <= flags_r;
        `IHW_ADDR_PORT_OUT: rdata_r <= port_r;
        default: rdata_r <= `IHW_RST_BYTE;
      endcase
    end
  end
  assign core.reg_ack = ack_r;
  assign core.reg_rdata = rdata_r;

  // ****************************************************************
  // Watchdog and reset generation
  // ****************************************************************

  // Free-running tick stands in for the watchdog's own oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_div_r <= 32'd0;
    end else if (wdt_div_r == 32'(WDT_DIV - 1)) begin
      wdt_div_r <= 32'd0;
    end else begin
      wdt_div_r <= wdt_div_r + 32'd1;
    end
  end
  assign wdt_tick = (wdt_div_r == 32'(WDT_DIV - 1));

  // Watchdog count, cannot be disabled, cleared by refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_r <= 32'd0;
    end else if (refresh || srst) begin
      wdt_cnt_r <= 32'd0;
    end else if (wdt_tick) begin
      wdt_cnt_r <= bite ? 32'd0 : wdt_cnt_r + 32'd1;
    end
  end
  assign bite = wdt_tick && (wdt_cnt_r == 32'(WDT_TICKS - 1));

  // Supply monitor synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
    end else begin
      lv_s1_r <= low_supply_trip_level;
      lv_s2_r <= lv_s1_r;
    end
  end

  // Reset held while supply is low, stretched after recovery or a bite
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= `IHW_RST_HOLD;
    end else if (lv_s2_r || bite) begin
      rst_cnt_r <= `IHW_RST_HOLD;
    end else if (rst_cnt_r != 5'd0) begin
      rst_cnt_r <= rst_cnt_r - 5'd1;
    end
  end
  assign srst = (rst_cnt_r != 5'd0);
  assign core.sys_reset = srst;
endmodule

//--- interrupt_halt_watchdog_unit_test.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module interrupt_halt_watchdog_unit_test;
  import ihw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic edge_input_one, edge_input_three, low_supply_trip_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] pre_end, cnt_end;
  ihw_byte_t port_out;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  ihw_if bus_if (.pclk(pclk), .presetn(presetn));
  ihw_unit #(.WDT_TICKS(100), .WDT_DIV(4)) u_ihw_unit (.core(bus_if.unit),
    .edge_input_one(edge_input_one), .edge_input_three(edge_input_three),
    .tmr_pre_end(pre_end), .tmr_cnt_end(cnt_end),
    .low_supply_trip_level(low_supply_trip_level), .port_out(port_out));
  ihw_core u_ihw_core (.unit(bus_if.core), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ihw_link_sva u_ihw_link_sva (.pclk(pclk), .presetn(presetn), .op_valid(bus_if.op_valid),
    .op_code(bus_if.op_code), .reg_req(bus_if.reg_req), .vf_ack(bus_if.vf_ack),
    .reg_ack(bus_if.reg_ack), .vf_req(bus_if.vf_req), .vf_addr(bus_if.vf_addr),
    .int_branch(bus_if.int_branch), .core_clk_en(bus_if.core_clk_en),
    .sys_reset(bus_if.sys_reset));
  // Clock
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic racc(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1, 12'h004, {15'h0, w, a, d});
    do apb(0, 12'h004, 0); while (rd[8] !== 1'b0);
  endtask
  task automatic swait(input int b, input logic v);
    do apb(0, 12'h008, 0); while (rd[b] !== v);
  endtask
  task automatic kick();
    apb(1, 12'h000, 32'h5f);
  endtask
  task automatic t_poll();
    kick();
    racc(1, 8'hfb, 8'h00);
    racc(1, 8'hfa, 8'h00);
    edge_input_three <= 0;
    @(posedge pclk);
    pre_end <= 2'b01;
    @(posedge pclk);
    pre_end <= 2'b00;
    cnt_end <= 2'b01;
    @(posedge pclk);
    pre_end <= 2'b10;
    cnt_end <= 2'b10;
    @(posedge pclk);
    pre_end <= 2'b00;
    cnt_end <= 2'b00;
    edge_input_three <= 1;
    racc(0, 8'hfa, 8'h00);
    chk(rd[7:0], 8'h09);
    racc(1, 8'hfa, 8'h00);
    racc(0, 8'hfa, 8'h00);
    chk(rd[7:0], 8'h00);
    apb(0, 12'h100, 0);
    chk(se, 1'b1);
  endtask
  task automatic t_grant();
    for (int i = 0; i < 12; i++) apb(1, 12'(12'h040 + 4 * i), 32'h10 + i);
    kick();
    racc(1, 8'hf9, 8'h27);
    racc(1, 8'hfa, 8'h09);
    racc(1, 8'hfb, 8'h89);
    swait(4, 1);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h1a1b);
    racc(0, 8'hfa, 8'h00);
    chk(rd[7:0], 8'h01);
    racc(0, 8'hfb, 8'h00);
    chk(rd[7:0], 8'h09);
    apb(1, 12'h008, 32'h10);
    apb(1, 12'h000, 32'hbf);
    swait(4, 1);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h1213);
  endtask
  task automatic t_halt();
    kick();
    racc(1, 8'h02, 8'ha5);
    racc(1, 8'hfb, 8'h82);
    apb(1, 12'h008, 32'h10);
    apb(1, 12'h00c, 32'h300);
    apb(1, 12'h000, 32'h7f);
    swait(0, 1);
    chk(port_out, 8'ha5);
    edge_input_one <= 0;
    swait(4, 1);
    edge_input_one <= 1;
    apb(0, 12'h00c, 0);
    chk(rd, 32'h1415);
    apb(1, 12'h000, 32'hbf);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h302);
  endtask
  task automatic t_wdt();
    int t0;
    racc(1, 8'hfc, 8'hc4);
    racc(1, 8'hfb, 8'h04);
    repeat (6) begin
      kick();
      t0 = cyc;
      repeat (250) @(posedge pclk);
    end
    apb(0, 12'h008, 0);
    chk(rd[1], 1'b0);
    racc(0, 8'hfb, 8'h00);
    chk(rd[7:0], 8'h04);
    racc(0, 8'hfc, 8'h00);
    chk(rd[7:0], 8'hc4);
    swait(1, 1);
    chk((cyc - t0) >= 396 && (cyc - t0) <= 420, 1'b1);
    swait(1, 0);
    racc(0, 8'hfb, 8'h00);
    chk(rd[7:0], 8'h00);
  endtask
  task automatic t_lowv();
    racc(1, 8'hfb, 8'h81);
    low_supply_trip_level <= 1;
    swait(1, 1);
    low_supply_trip_level <= 0;
    swait(1, 0);
    racc(0, 8'hfb, 8'h00);
    chk(rd[7:0], 8'h00);
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, low_supply_trip_level} = 0;
    {edge_input_one, edge_input_three} = 2'b11;
    {paddr, pwdata, pre_end, cnt_end} = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    swait(0, 0);
    t_poll();
    t_grant();
    t_halt();
    t_wdt();
    t_lowv();
    end_sim();
  end
endmodule
